/* qptu_pkg.sv */
package qptu_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------

  // Register select width (odd byte addresses up to 0x25).
  localparam int unsigned ADDR_W = 6;
  localparam logic [5:0] TIMER_A_CONTROL_OFS = 6'h19;
  localparam logic [5:0] TIMER_B_CONTROL_OFS = 6'h1b;
  localparam logic [5:0] TIMER_CD_CONTROL_OFS = 6'h1d;
  localparam logic [5:0] TIMER_A_DATA_OFS = 6'h1f;
  localparam logic [5:0] TIMER_B_DATA_OFS = 6'h21;
  localparam logic [5:0] TIMER_C_DATA_OFS = 6'h23;
  localparam logic [5:0] TIMER_D_DATA_OFS = 6'h25;

  // ----------------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------------

  // Reset value of every control and data register.
  localparam logic [7:0] REG_RESET = 8'h00;
  // Output-reset bit position in timer A and B control registers.
  localparam int unsigned FORCE_LOW_BIT = 4;
  // Readable mask of timer A and B control registers.
  localparam logic [7:0] AB_CTRL_MASK = 8'h0f;
  // Readable mask of the timer C/D control register.
  localparam logic [7:0] CD_CTRL_MASK = 8'h77;
  // Position of the timer C mode field.
  localparam int unsigned C_MODE_LSB = 4;
  // Edge register bits for the two auxiliary inputs.
  localparam int unsigned EDGE_BIT_LINE4 = 4;
  localparam int unsigned EDGE_BIT_LINE3 = 3;
  // Counter value at which the next count pulse times out.
  localparam logic [7:0] TERMINAL_COUNT = 8'h01;
  localparam logic [7:0] COUNT_STEP = 8'h01;

  // ----------------------------------------------------------------------
  // Modes and prescaler divisors
  // ----------------------------------------------------------------------

  // Mode code meaning stopped.
  localparam logic [2:0] DIV_STOP = 3'h0;
  // Event count code for timers A and B.
  localparam logic [3:0] MODE_EVENT = 4'h8;
  // Prescaler divisors for selector codes 1 to 7.
  localparam logic [7:0] DIV_1 = 8'h04;
  localparam logic [7:0] DIV_2 = 8'h0a;
  localparam logic [7:0] DIV_3 = 8'h10;
  localparam logic [7:0] DIV_4 = 8'h32;
  localparam logic [7:0] DIV_5 = 8'h40;
  localparam logic [7:0] DIV_6 = 8'h64;
  localparam logic [7:0] DIV_7 = 8'hc8;
  localparam logic [7:0] PRESCALE_ONE = 8'h01;
  localparam logic [7:0] PRESCALE_ZERO = 8'h00;

  // Decoded operation of one timer.
  typedef enum logic [3:0] {
    QPTU_OP_STOP = 4'b0001,
    QPTU_OP_DELAY = 4'b0010,
    QPTU_OP_EVENT = 4'b0100,
    QPTU_OP_PULSE = 4'b1000
  } qptu_op_type;

  // Host bus request carried into the block.
  typedef struct packed {
    logic cs;
    logic wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } qptu_bus_req_type;

  // Per-timer steering from the register side.
  typedef struct packed {
    qptu_op_type op;
    logic [2:0] div_sel;
    logic aux_level;
    logic edge_bit;
  } qptu_timer_ctl_type;

  // Divisor lookup for a 3-bit prescaler selector.
  function automatic logic [7:0] div_of(input logic [2:0] sel);
    logic [7:0] d;
    d = DIV_1;
    unique case (sel)
      3'h1: d = DIV_1;
      3'h2: d = DIV_2;
      3'h3: d = DIV_3;
      3'h4: d = DIV_4;
      3'h5: d = DIV_5;
      3'h6: d = DIV_6;
      3'h7: d = DIV_7;
      default: d = DIV_1;
    endcase
    return d;
  endfunction : div_of

endpackage : qptu_pkg

/* qptu_timer.sv */
module qptu_timer (
  // Clock, reset and enable.
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // Steering from the register side.
  input wire qptu_pkg::qptu_timer_ctl_type ctl_i,
  input wire logic edge_pulse_i,
  input wire logic force_low_i,
  input wire logic data_wr_i,
  input wire logic [7:0] data_i,
  // Timer state.
  output logic [7:0] count_o,
  output logic timeout_o,
  output logic out_o
);

  // ----------------------------------------------------------------------
  // Count pulse source
  // ----------------------------------------------------------------------

  // Prescaler counter, main down counter and reload register.
  logic [7:0] pre_q;
  logic [7:0] pre_d;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [7:0] reload_q;
  logic out_q;

  // Divisor for the current selector.
  wire logic [7:0] div_w = qptu_pkg::div_of(ctl_i.div_sel);
  // Prescaled modes run; pulse width only while aux is at its active level.
  wire logic pre_run_w = (ctl_i.op == qptu_pkg::QPTU_OP_DELAY) ||
                         ((ctl_i.op == qptu_pkg::QPTU_OP_PULSE) && ctl_i.aux_level);
  // Prescaler wrap yields one count pulse.
  wire logic pre_tick_w = pre_run_w && (pre_q == div_w - qptu_pkg::PRESCALE_ONE);
  // Event count bypasses the prescaler: one pulse per active edge.
  wire logic count_w = pre_tick_w ||
                       ((ctl_i.op == qptu_pkg::QPTU_OP_EVENT) && edge_pulse_i);
  wire logic stopped_w = (ctl_i.op == qptu_pkg::QPTU_OP_STOP);
  wire logic tout_w = count_w && (cnt_q == qptu_pkg::TERMINAL_COUNT);

  // Prescaler next value: cleared when stopped or wrapped, holds when gated.
  always_comb begin
    pre_d = pre_q;
    if (!pre_run_w && stopped_w) begin
      pre_d = qptu_pkg::PRESCALE_ZERO;
    end else if (pre_tick_w) begin
      pre_d = qptu_pkg::PRESCALE_ZERO;
    end else if (pre_run_w) begin
      pre_d = pre_q + qptu_pkg::PRESCALE_ONE;
    end
  end

  // Main counter next value.
  always_comb begin
    cnt_d = cnt_q;
    if (data_wr_i && stopped_w) begin
      cnt_d = data_i;
    end else if (tout_w) begin
      cnt_d = reload_q;
    end else if (count_w) begin
      cnt_d = cnt_q - qptu_pkg::COUNT_STEP;
    end
  end

  // ----------------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------------

  // Counters, reload value and output toggle.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pre_q <= qptu_pkg::PRESCALE_ZERO;
      cnt_q <= qptu_pkg::REG_RESET;
      reload_q <= qptu_pkg::REG_RESET;
      out_q <= 1'b0;
    end else if (clk_en_i) begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
      if (data_wr_i) begin
        reload_q <= data_i;
      end
      if (force_low_i) begin
        out_q <= 1'b0;
      end else if (tout_w) begin
        out_q <= ~out_q;
      end
    end
  end

  assign count_o = cnt_q;
  assign timeout_o = tout_w && clk_en_i;
  assign out_o = out_q;

endmodule : qptu_timer

/* qptu_top.sv */
module qptu_top (
  // Clock, reset and enable.
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // Host register port; a data strobe marks each access.
  input wire qptu_pkg::qptu_bus_req_type bus_req_i,
  input wire logic data_strobe_i,
  output logic [7:0] rdata_o,
  // Edge select register contents and raw port lines 3 and 4.
  input wire logic [7:0] edge_select_register_i,
  input wire logic port_line_3_i,
  input wire logic port_line_4_i,
  // Auxiliary inputs from outside.
  input wire logic aux_input_a_i,
  input wire logic aux_input_b_i,
  // Timer outputs and timeout pulses.
  output logic timer_a_output_o,
  output logic timer_b_output_o,
  output logic timer_c_output_o,
  output logic timer_d_output_o,
  output logic [3:0] timeout_o,
  // Interrupt channel sources for port lines 4 and 3 and their edge bits.
  output logic line4_irq_src_o,
  output logic line3_irq_src_o,
  output logic line4_irq_edge_o,
  output logic line3_irq_edge_o
);

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------

  // Mode fields of the four timers.
  logic [3:0] timer_a_mode_field_q;
  logic [3:0] timer_b_mode_field_q;
  logic [2:0] timer_c_mode_field_q;
  logic [2:0] timer_d_mode_field_q;
  // Captured counter values and auxiliary synchronisers.
  logic [7:0] cap_q [4];
  logic [2:0] aux_a_sync_q;
  logic [2:0] aux_b_sync_q;
  logic aux_a_q;
  logic aux_b_q;
  logic strobe_q;
  logic [7:0] rdata_q;

  // Access decode.
  wire logic wr_w = bus_req_i.cs && bus_req_i.wr && data_strobe_i;
  wire logic wr_a_ctl_w = wr_w && (bus_req_i.addr == qptu_pkg::TIMER_A_CONTROL_OFS);
  wire logic wr_b_ctl_w = wr_w && (bus_req_i.addr == qptu_pkg::TIMER_B_CONTROL_OFS);
  wire logic wr_cd_ctl_w = wr_w && (bus_req_i.addr == qptu_pkg::TIMER_CD_CONTROL_OFS);
  wire logic [3:0] wr_data_w = {
    wr_w && (bus_req_i.addr == qptu_pkg::TIMER_D_DATA_OFS),
    wr_w && (bus_req_i.addr == qptu_pkg::TIMER_C_DATA_OFS),
    wr_w && (bus_req_i.addr == qptu_pkg::TIMER_B_DATA_OFS),
    wr_w && (bus_req_i.addr == qptu_pkg::TIMER_A_DATA_OFS)};
  // Rising edge of the data strobe captures the counters.
  wire logic strobe_rise_w = data_strobe_i && !strobe_q;

  // Control register writes; the force bit is not stored and reads back as zero.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      timer_a_mode_field_q <= qptu_pkg::REG_RESET[3:0];
      timer_b_mode_field_q <= qptu_pkg::REG_RESET[3:0];
      timer_c_mode_field_q <= qptu_pkg::REG_RESET[2:0];
      timer_d_mode_field_q <= qptu_pkg::REG_RESET[2:0];
    end else if (clk_en_i) begin
      if (wr_a_ctl_w) begin
        timer_a_mode_field_q <= bus_req_i.wdata[3:0];
      end
      if (wr_b_ctl_w) begin
        timer_b_mode_field_q <= bus_req_i.wdata[3:0];
      end
      if (wr_cd_ctl_w) begin
        timer_c_mode_field_q <= bus_req_i.wdata[qptu_pkg::C_MODE_LSB +: 3];
        timer_d_mode_field_q <= bus_req_i.wdata[2:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Auxiliary input conditioning
  // ----------------------------------------------------------------------

  // Three-stage synchronisers; a change counts once stages two and three agree.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      aux_a_sync_q <= 3'h0;
      aux_b_sync_q <= 3'h0;
      aux_a_q <= 1'b0;
      aux_b_q <= 1'b0;
      strobe_q <= 1'b0;
    end else if (clk_en_i) begin
      aux_a_sync_q <= {aux_a_sync_q[1:0], aux_input_a_i};
      aux_b_sync_q <= {aux_b_sync_q[1:0], aux_input_b_i};
      if (aux_a_sync_q[1] == aux_a_sync_q[2]) begin
        aux_a_q <= aux_a_sync_q[2];
      end
      if (aux_b_sync_q[1] == aux_b_sync_q[2]) begin
        aux_b_q <= aux_b_sync_q[2];
      end
      strobe_q <= data_strobe_i;
    end
  end

  wire logic edge_a_w = edge_select_register_i[qptu_pkg::EDGE_BIT_LINE4];
  wire logic edge_b_w = edge_select_register_i[qptu_pkg::EDGE_BIT_LINE3];
  // Edge bit xnor input gives active level.
  // Toggling the edge bit shifts that level and may count.
  wire logic lvl_a_w = aux_a_q ~^ edge_a_w;
  wire logic lvl_b_w = aux_b_q ~^ edge_b_w;
  logic lvl_a_q;
  logic lvl_b_q;

  // Previous active level, for transition detection after the edge select.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      lvl_a_q <= 1'b0;
      lvl_b_q <= 1'b0;
    end else if (clk_en_i) begin
      lvl_a_q <= lvl_a_w;
      lvl_b_q <= lvl_b_w;
    end
  end

  // ----------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------

  // Decode a four-bit A/B mode field.
  function automatic qptu_pkg::qptu_op_type ab_op(input logic [3:0] m);
    qptu_pkg::qptu_op_type op;
    if (m[2:0] == qptu_pkg::DIV_STOP) begin
      op = (m == qptu_pkg::MODE_EVENT) ? qptu_pkg::QPTU_OP_EVENT : qptu_pkg::QPTU_OP_STOP;
    end else begin
      op = m[3] ? qptu_pkg::QPTU_OP_PULSE : qptu_pkg::QPTU_OP_DELAY;
    end
    return op;
  endfunction : ab_op

  // Decode a three-bit C/D mode field.
  function automatic qptu_pkg::qptu_op_type cd_op(input logic [2:0] m);
    return (m == qptu_pkg::DIV_STOP) ? qptu_pkg::QPTU_OP_STOP : qptu_pkg::QPTU_OP_DELAY;
  endfunction : cd_op

  // Steering bundles for each timer.
  qptu_pkg::qptu_timer_ctl_type ctl_w [4];
  assign ctl_w[0] = '{op: ab_op(timer_a_mode_field_q), div_sel: timer_a_mode_field_q[2:0],
                      aux_level: lvl_a_w, edge_bit: edge_a_w};
  assign ctl_w[1] = '{op: ab_op(timer_b_mode_field_q), div_sel: timer_b_mode_field_q[2:0],
                      aux_level: lvl_b_w, edge_bit: edge_b_w};
  assign ctl_w[2] = '{op: cd_op(timer_c_mode_field_q), div_sel: timer_c_mode_field_q,
                      aux_level: 1'b0, edge_bit: 1'b0};
  assign ctl_w[3] = '{op: cd_op(timer_d_mode_field_q), div_sel: timer_d_mode_field_q,
                      aux_level: 1'b0, edge_bit: 1'b0};

  // Active transition pulses for event count.
  wire logic [3:0] edge_pulse_w = {2'b00, lvl_b_w && !lvl_b_q, lvl_a_w && !lvl_a_q};
  // Force-low acts in the write cycle itself, so the output is low after it.
  wire logic [3:0] force_w = {2'b00,
                              wr_b_ctl_w && bus_req_i.wdata[qptu_pkg::FORCE_LOW_BIT],
                              wr_a_ctl_w && bus_req_i.wdata[qptu_pkg::FORCE_LOW_BIT]};
  wire logic [3:0] out_w;
  logic [7:0] count_w [4];

  // ----------------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------------

  for (genvar t = 0; t < 4; t++) begin : g_timer
    qptu_timer u_timer (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .clk_en_i(clk_en_i),
      .ctl_i(ctl_w[t]),
      .edge_pulse_i(edge_pulse_w[t]),
      .force_low_i(force_w[t]),
      .data_wr_i(wr_data_w[t]),
      .data_i(bus_req_i.wdata),
      .count_o(count_w[t]),
      .timeout_o(timeout_o[t]),
      .out_o(out_w[t])
    );
  end

  // Capture counters on each rising data strobe.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < 4; i++) begin
        cap_q[i] <= qptu_pkg::REG_RESET;
      end
    end else if (clk_en_i && strobe_rise_w) begin
      for (int i = 0; i < 4; i++) begin
        cap_q[i] <= count_w[i];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------

  // Unused control bits masked to zero.
  logic [7:0] rsel_w;
  always_comb begin
    rsel_w = 8'h00;
    unique case (bus_req_i.addr)
      qptu_pkg::TIMER_A_CONTROL_OFS: rsel_w = {4'h0, timer_a_mode_field_q} & qptu_pkg::AB_CTRL_MASK;
      qptu_pkg::TIMER_B_CONTROL_OFS: rsel_w = {4'h0, timer_b_mode_field_q} & qptu_pkg::AB_CTRL_MASK;
      qptu_pkg::TIMER_CD_CONTROL_OFS: rsel_w = {1'b0, timer_c_mode_field_q, 1'b0,
                                               timer_d_mode_field_q} & qptu_pkg::CD_CTRL_MASK;
      qptu_pkg::TIMER_A_DATA_OFS: rsel_w = cap_q[0];
      qptu_pkg::TIMER_B_DATA_OFS: rsel_w = cap_q[1];
      qptu_pkg::TIMER_C_DATA_OFS: rsel_w = cap_q[2];
      qptu_pkg::TIMER_D_DATA_OFS: rsel_w = cap_q[3];
      default: rsel_w = 8'h00;
    endcase
  end

  // Registered read data.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_q <= qptu_pkg::REG_RESET;
    end else if (clk_en_i && bus_req_i.cs && !bus_req_i.wr) begin
      rdata_q <= rsel_w;
    end
  end
  assign rdata_o = rdata_q;

  // ----------------------------------------------------------------------
  // Outputs and interrupt source steering
  // ----------------------------------------------------------------------

  // Outputs low from reset via the cores.
  assign timer_a_output_o = out_w[0];
  assign timer_b_output_o = out_w[1];
  assign timer_c_output_o = out_w[2];
  assign timer_d_output_o = out_w[3];

  // Only pulse-width mode redirects lines, with inverted edge.
  wire logic pw_a_w = (ctl_w[0].op == qptu_pkg::QPTU_OP_PULSE);
  wire logic pw_b_w = (ctl_w[1].op == qptu_pkg::QPTU_OP_PULSE);
  assign line4_irq_src_o = pw_a_w ? aux_a_q : port_line_4_i;
  assign line3_irq_src_o = pw_b_w ? aux_b_q : port_line_3_i;
  assign line4_irq_edge_o = pw_a_w ? !edge_a_w : edge_a_w;
  assign line3_irq_edge_o = pw_b_w ? !edge_b_w : edge_b_w;

endmodule : qptu_top

/* qptu_chk.sv */
module qptu_chk (
  // Clock, reset and enable.
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // Host port.
  input wire qptu_pkg::qptu_bus_req_type bus_req_i,
  input wire logic data_strobe_i,
  input wire logic [7:0] rdata_o,
  // Edge bits and port line 4.
  input wire logic [7:0] edge_select_register_i,
  input wire logic port_line_4_i,
  // Timer A output, timeouts and the line 4 interrupt source.
  input wire logic timer_a_output_o,
  input wire logic [3:0] timeout_o,
  input wire logic line4_irq_src_o,
  input wire logic line4_irq_edge_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // Enabled write to the timer A control register, and its force-low form.
  wire logic wr_a = bus_req_i.cs && bus_req_i.wr && data_strobe_i && clk_en_i
    && (bus_req_i.addr == qptu_pkg::TIMER_A_CONTROL_OFS);
  wire logic force_a = wr_a && bus_req_i.wdata[qptu_pkg::FORCE_LOW_BIT];
  // Shadow of the timer A mode field.
  logic [3:0] mode_a_q;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mode_a_q <= 4'h0;
    end else if (wr_a) begin
      mode_a_q <= bus_req_i.wdata[3:0];
    end
  end
  wire logic pw_a = mode_a_q[3] && (mode_a_q[2:0] != 3'h0);
  wire logic stop_a = (mode_a_q == 4'h0);

  // A read cycle at one address.
  sequence s_rd(logic [5:0] a);
    bus_req_i.cs && !bus_req_i.wr && clk_en_i && (bus_req_i.addr == a);
  endsequence

  a_reset_out_low: assert property ($fell(sys_rst_i) |->
    !timer_a_output_o && (timeout_o == 4'h0)) else $error("output active after reset");
  a_force_holds_low: assert property (force_a |=> !timer_a_output_o)
    else $error("forced output not low");
  a_timeout_toggles: assert property (timeout_o[0] && !force_a && clk_en_i |=>
    (timer_a_output_o != $past(timer_a_output_o))) else $error("output missed toggle");
  a_output_quiet: assert property (!timeout_o[0] && !force_a && clk_en_i |=>
    $stable(timer_a_output_o)) else $error("output changed without timeout");
  a_ab_ctrl_mask: assert property (s_rd(qptu_pkg::TIMER_A_CONTROL_OFS) |=>
    ((rdata_o & ~qptu_pkg::AB_CTRL_MASK) == 8'h00)) else $error("unused bit set");
  a_cd_ctrl_mask: assert property (s_rd(qptu_pkg::TIMER_CD_CONTROL_OFS) |=>
    ((rdata_o & ~qptu_pkg::CD_CTRL_MASK) == 8'h00)) else $error("unused bit set");
  a_stop_no_timeout: assert property (stop_a && $past(stop_a) |-> !timeout_o[0])
    else $error("timeout while stopped");
  a_irq_normal_line: assert property (!pw_a |-> (line4_irq_src_o == port_line_4_i)
    && (line4_irq_edge_o == edge_select_register_i[4])) else $error("line 4 redirected");
  a_irq_pulse_edge: assert property (pw_a |->
    (line4_irq_edge_o == !edge_select_register_i[4])) else $error("edge not inverted");
  a_timeout_single: assert property ((timeout_o != 4'h0) |=>
    ((timeout_o & $past(timeout_o)) == 4'h0)) else $error("timeout longer than a cycle");
endmodule : qptu_chk

bind qptu_top qptu_chk CHK (
  .clk_i, .sys_rst_i, .clk_en_i, .bus_req_i, .data_strobe_i, .rdata_o,
  .edge_select_register_i, .port_line_4_i, .timer_a_output_o, .timeout_o,
  .line4_irq_src_o, .line4_irq_edge_o
);

/* qptu_host_model.sv */
module qptu_host_model (
  // Clock and read data.
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  // Requests towards the block.
  output qptu_pkg::qptu_bus_req_type bus_req_o,
  output logic data_strobe_o,
  // Event sources.
  output logic aux_a_o,
  output logic aux_b_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle at time zero.
  initial begin
    bus_req_o = '0;
    data_strobe_o = 1'b0;
    aux_a_o = 1'b0;
    aux_b_o = 1'b0;
  end

  // Ends a cycle; cs, wr and strobe go low, address and data lines show the inverse of their last value.
  task automatic release_bus();
    bus_req_o.cs = 1'b0;
    bus_req_o.wr = 1'b0;
    bus_req_o.addr = ~bus_req_o.addr;
    bus_req_o.wdata = ~bus_req_o.wdata;
    data_strobe_o = 1'b0;
  endtask : release_bus

  // Starts a strobed cycle just after an edge.
  task automatic start(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    bus_req_o = '{cs: 1'b1, wr: w, addr: a, wdata: d};
    data_strobe_o = 1'b1;
  endtask : start

  // A write is taken at the first edge.
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    start(1'b1, a, d);
    @(posedge clk_i);
    #1;
    release_bus();
  endtask : wr

  // The strobe edge captures the counters; data is taken after the third edge.
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    start(1'b0, a, 8'h5a);
    repeat (3) @(posedge clk_i);
    #1;
    d = rdata_i;
    release_bus();
  endtask : rd

  task automatic aux(input logic b, input logic v);
    @(posedge clk_i);
    #1;
    if (b) begin
      aux_b_o = v;
    end else begin
      aux_a_o = v;
    end
    repeat (6) @(posedge clk_i);
  endtask : aux
endmodule : qptu_host_model

/* quad_prescaled_timer_unit_tb.sv */
module quad_prescaled_timer_unit_tb;
  timeunit 1ns;
  timeprecision 100ps;

  // Stimulus, outputs and bench state.
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] edge_sel = 8'h10;
  logic line4 = 1'b0;
  qptu_pkg::qptu_bus_req_type bus_req;
  logic strobe;
  logic aux_a;
  logic aux_b;
  logic [7:0] rdata;
  wire [3:0] outs;
  wire [3:0] tmo;
  wire src4;
  wire edge4;
  int n_fail = 0;
  int n_checks = 0;
  int divs[8] = '{0, 4, 10, 16, 50, 64, 100, 200};
  logic [5:0] regs[7] = '{6'h19, 6'h1b, 6'h1d, 6'h1f, 6'h21, 6'h23, 6'h25};

  always #5 clk_i = ~clk_i;

  qptu_top DUT (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(1'b1),
    .bus_req_i(bus_req),
    .data_strobe_i(strobe),
    .rdata_o(rdata),
    .edge_select_register_i(edge_sel),
    .port_line_3_i(1'b0),
    .port_line_4_i(line4),
    .aux_input_a_i(aux_a),
    .aux_input_b_i(aux_b),
    .timer_a_output_o(outs[0]),
    .timer_b_output_o(outs[1]),
    .timer_c_output_o(outs[2]),
    .timer_d_output_o(outs[3]),
    .timeout_o(tmo),
    .line4_irq_src_o(src4),
    .line3_irq_src_o(),
    .line4_irq_edge_o(edge4),
    .line3_irq_edge_o()
  );

  qptu_host_model HOST (
    .clk_i(clk_i),
    .rdata_i(rdata),
    .bus_req_o(bus_req),
    .data_strobe_o(strobe),
    .aux_a_o(aux_a),
    .aux_b_o(aux_b)
  );

  // Compares a byte and reports a mismatch at once.
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  // Compares a cycle count.
  task automatic chk_cnt(input int got, input int exp);
    n_checks++;
    if (got != exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_cnt

  // Reads a register and compares it.
  task automatic rdchk(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] d;
    HOST.rd(a, d);
    chk8(d, exp);
  endtask : rdchk

  // Measures the spacing of two timeouts and the output toggle between them.
  task automatic period(input int i, input int exp);
    int n;
    logic o;
    n = 0;
    while (tmo[i] !== 1'b1 && n < 3000) begin
      @(posedge clk_i);
      #2;
      n++;
    end
    o = outs[i];
    n = 0;
    do begin
      @(posedge clk_i);
      #2;
      n++;
    end while (tmo[i] !== 1'b1 && n < 3000);
    chk_cnt(n, exp);
    chk8({7'h00, outs[i]}, {7'h00, ~o});
  endtask : period

  // Prints the closing counts and the verdict.
  task automatic final_report();
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report

  // Watchdog; the tests need about 6000 cycles.
  initial begin
    #500000;
    n_fail++;
    final_report();
  end

  // Main sequence.
  initial begin
    int hits;
    repeat (3) @(posedge clk_i);
    #1;
    sys_rst_i = 1'b0;
    foreach (regs[k]) rdchk(regs[k], 8'h00);
    chk8({4'h0, outs}, 8'h00);
    rdchk(6'h01, 8'h00);
    HOST.wr(6'h19, 8'hef);
    rdchk(6'h19, 8'h0f);
    HOST.wr(6'h1b, 8'he8);
    rdchk(6'h1b, 8'h08);
    HOST.wr(6'h1d, 8'hff);
    rdchk(6'h1d, 8'h77);
    for (int k = 0; k < 3; k++) HOST.wr(regs[k], 8'h00);
    $display("test registers done");
    HOST.aux(1'b0, 1'b1);
    HOST.wr(6'h1f, 8'h01);
    for (int c = 1; c < 16; c++) begin
      if (c != 8) begin
        HOST.wr(6'h19, 8'(c));
        period(0, divs[c % 8]);
      end
    end
    HOST.wr(6'h19, 8'h09);
    HOST.aux(1'b0, 1'b0);
    hits = 0;
    repeat (60) begin
      @(posedge clk_i);
      #2;
      hits += int'(tmo[0] === 1'b1);
    end
    chk_cnt(hits, 0);
    HOST.wr(6'h23, 8'h01);
    HOST.wr(6'h25, 8'h01);
    for (int c = 1; c < 8; c++) begin
      HOST.wr(6'h1d, {1'b0, 3'(c), 1'b0, 3'(c)});
      period(2, divs[c]);
      period(3, divs[c]);
    end
    HOST.wr(6'h1d, 8'h00);
    HOST.wr(6'h25, 8'h00);
    HOST.wr(6'h1d, 8'h01);
    period(3, 1024);
    HOST.wr(6'h1d, 8'h00);
    $display("test delay done");
    HOST.wr(6'h19, 8'h00);
    HOST.wr(6'h1f, 8'h05);
    rdchk(6'h1f, 8'h05);
    HOST.wr(6'h21, 8'h05);
    HOST.wr(6'h19, 8'h08);
    HOST.wr(6'h1b, 8'h08);
    HOST.aux(1'b0, 1'b1);
    rdchk(6'h1f, 8'h04);
    HOST.aux(1'b0, 1'b0);
    rdchk(6'h1f, 8'h04);
    HOST.aux(1'b1, 1'b1);
    rdchk(6'h21, 8'h05);
    HOST.aux(1'b1, 1'b0);
    rdchk(6'h21, 8'h04);
    HOST.wr(6'h1f, 8'h02);
    rdchk(6'h1f, 8'h04);
    HOST.wr(6'h19, 8'h18);
    chk8({7'h00, outs[0]}, 8'h00);
    repeat (4) begin
      HOST.aux(1'b0, 1'b1);
      HOST.aux(1'b0, 1'b0);
    end
    rdchk(6'h1f, 8'h02);
    chk8({7'h00, outs[0]}, 8'h01);
    HOST.wr(6'h19, 8'h00);
    HOST.aux(1'b0, 1'b1);
    HOST.aux(1'b0, 1'b0);
    rdchk(6'h1f, 8'h02);
    HOST.wr(6'h19, 8'h08);
    @(posedge clk_i);
    #1;
    line4 = 1'b1;
    #1;
    chk8({6'h00, src4, edge4}, 8'h03);
    line4 = 1'b0;
    HOST.wr(6'h19, 8'h09);
    HOST.aux(1'b0, 1'b1);
    chk8({6'h00, src4, edge4}, 8'h02);
    HOST.wr(6'h19, 8'h00);
    $display("test events done");
    final_report();
  end
endmodule : quad_prescaled_timer_unit_tb
